// *** logic/uart_frame_tx.sv ***
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module uart_frame_tx
    import uart_frame_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Register port
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    // Receive side and transmit-complete acknowledge
    input  wire logic       i_rxd,
    input  wire logic       i_rx_done,
    input  wire logic       i_rx_ninth,
    input  wire logic       i_tx_done_ack,
    output logic            o_frame_error,
    // Serial line and requests
    output logic            o_txd,
    output logic            o_txd_oe,
    output logic            o_empty_irq,
    output logic            o_done_irq
);

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]   control;
    logic [7:0]   format;
    logic [11:0]  baud_div;
    logic         double_speed;
    logic [8:0]   tx_buffer;
    logic         buffer_full;
    logic         tx_done;
    logic         frame_error;
    logic         tx_active;

    // Transmit state
    tx_state_type state;
    tx_state_type next_state;
    logic [8:0]   shifter;
    logic         parity_bit;
    logic [3:0]   bit_count;
    logic [3:0]   tick_count;
    logic [11:0]  baud_count;

    // Receive pin synchroniser and checker
    logic         rxd_meta;
    logic         rxd_sync;
    logic         rx_busy;
    logic [3:0]   rx_ticks;
    logic [3:0]   rx_bits;

    ////////////////////////////////////////////////////////////////////
    // Decode
    logic        wr_data;
    logic        wr_status;
    logic        wr_control;
    logic        wr_format;
    logic        wr_baud_hi;
    logic        wr_baud_lo;
    logic [2:0]  char_size;
    logic [3:0]  data_bits;
    logic        parity_on;
    logic        two_stops;
    logic        baud_tick;
    logic        bit_tick;
    logic [3:0]  ticks_per_bit;
    logic        frame_end;
    logic        load_shifter;
    logic [8:0]  masked_char;
    logic        gen_parity;
    logic [8:0]  buffer_word;

    assign wr_data    = i_wr && (i_addr == ADDR_DATA);
    assign wr_status  = i_wr && (i_addr == ADDR_STATUS);
    assign wr_control = i_wr && (i_addr == ADDR_CONTROL);
    // Shared location, top bit picks the format register
    assign wr_format  = i_wr && (i_addr == ADDR_FORMAT) && i_wdata[FM_SELECT];
    assign wr_baud_hi = i_wr && (i_addr == ADDR_FORMAT) && !i_wdata[FM_SELECT];
    assign wr_baud_lo = i_wr && (i_addr == ADDR_BAUD_LO);

    // One shared format for both directions
    assign char_size  = {control[CT_CHAR_HI], format[FM_CHAR_HI:FM_CHAR_LO]};
    assign data_bits  = (char_size == CHAR_9) ? 4'h9 :
                        char_size[2] ? 4'h8 : {2'b00, char_size[1:0]} + 4'h5;
    assign parity_on  = format[FM_PAR_HI];
    assign two_stops  = format[FM_STOP2];
    assign ticks_per_bit = double_speed ? TICKS_DOUBLE : TICKS_NORMAL;

    // Divider gives a one-cycle enable, not a clock
    assign baud_tick  = (baud_count == 12'h000);
    assign bit_tick   = baud_tick && (tick_count == ticks_per_bit);

    // Frame ends on the last stop bit; two stops both run first
    assign frame_end  = bit_tick && ((state == TX_STOP2) ||
                                     ((state == TX_STOP1) && !two_stops));
    // Load when idle or right at the end of the previous frame
    assign load_shifter = buffer_full && control[CT_TX_EN] &&
                          ((state == TX_IDLE) || frame_end);

    // Ninth bit taken from the control bit at write time
    assign buffer_word = {control[CT_TX_NINTH], i_wdata};

    uart_parity_gen parity_unit (
        .i_data      (tx_buffer),
        .i_char_size (char_size),
        .i_odd       (format[FM_PAR_LO]),
        .o_masked    (masked_char),
        .o_parity    (gen_parity)
    );

    ////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            control      <= CONTROL_RESET;
            format       <= FORMAT_RESET;
            baud_div     <= BAUD_RESET;
            double_speed <= 1'b0;
        end else begin
            if (wr_control) begin
                // Receive ninth bit is read-only
                control <= {i_wdata[7:2], control[CT_RX_NINTH], i_wdata[0]};
            end
            if (wr_format) begin
                format <= i_wdata;
            end
            if (wr_baud_hi) begin
                baud_div[11:8] <= i_wdata[3:0];
            end
            if (wr_baud_lo) begin
                baud_div[7:0] <= i_wdata;
            end
            // Buffer-empty position is read-only; writing zero is expected
            if (wr_status) begin
                double_speed <= i_wdata[ST_DOUBLE];
            end
        end
    end

    // Transmit buffer and its empty flag
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tx_buffer   <= 9'h000;
            buffer_full <= 1'b0;
        end else if (wr_data) begin
            tx_buffer   <= buffer_word;
            buffer_full <= 1'b1;
        end else if (load_shifter) begin
            buffer_full <= 1'b0;
        end
    end

    // Complete flag: set wins over the write-one clear
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tx_done <= 1'b0;
        end else if (frame_end && !buffer_full) begin
            tx_done <= 1'b1;
        end else if ((wr_status && i_wdata[ST_TX_DONE]) || i_tx_done_ack) begin
            tx_done <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Baud divider, cleared to zero on low-byte write so it ticks next cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn || wr_baud_lo) begin
            baud_count <= 12'h000;
        end else if (baud_tick) begin
            baud_count <= baud_div;
        end else begin
            baud_count <= baud_count - 12'h001;
        end
    end

    // Sub-bit tick counter; restarts on a fresh frame so the start bit is full
    always_ff @(posedge i_clk) begin
        if (!i_resetn || (state == TX_IDLE)) begin
            tick_count <= 4'h0;
        end else if (bit_tick) begin
            tick_count <= 4'h0;
        end else if (baud_tick) begin
            tick_count <= tick_count + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            TX_IDLE: begin
                if (load_shifter) begin
                    next_state = TX_START;
                end
            end
            TX_START: begin
                if (bit_tick) begin
                    next_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (bit_tick && (bit_count == data_bits - 4'h1)) begin
                    next_state = parity_on ? TX_PARITY : TX_STOP1;
                end
            end
            TX_PARITY: begin
                if (bit_tick) begin
                    next_state = TX_STOP1;
                end
            end
            TX_STOP1: begin
                if (bit_tick) begin
                    if (two_stops) begin
                        next_state = TX_STOP2;
                    end else begin
                        next_state = load_shifter ? TX_START : TX_IDLE;
                    end
                end
            end
            TX_STOP2: begin
                if (bit_tick) begin
                    next_state = load_shifter ? TX_START : TX_IDLE;
                end
            end
            default: begin
                next_state = TX_IDLE;
            end
        endcase
    end

    // Shifter, bit counter and parity capture
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state      <= TX_IDLE;
            shifter    <= 9'h000;
            bit_count  <= 4'h0;
            parity_bit <= 1'b0;
        end else begin
            state <= next_state;
            if (load_shifter) begin
                shifter    <= masked_char;
                parity_bit <= gen_parity;
                bit_count  <= 4'h0;
            end else if (bit_tick && (state == TX_DATA)) begin
                shifter    <= {1'b0, shifter[8:1]};
                bit_count  <= bit_count + 4'h1;
            end
        end
    end

    // Line level by frame position
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_txd <= 1'b1;
        end else begin
            case (next_state)
                TX_START:  o_txd <= 1'b0;
                TX_DATA:   o_txd <= (bit_tick && (state == TX_DATA)) ? shifter[1] : shifter[0];
                TX_PARITY: o_txd <= parity_bit;
                default:   o_txd <= 1'b1;
            endcase
        end
    end

    // Pin stays driven until the shifter drains after disable; a byte still in the buffer is not sent and keeps it driven
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tx_active <= 1'b0;
        end else if (control[CT_TX_EN]) begin
            tx_active <= 1'b1;
        end else if (!buffer_full && (state == TX_IDLE)) begin
            tx_active <= 1'b0;
        end
    end
    assign o_txd_oe = tx_active;

    ////////////////////////////////////////////////////////////////////
    // Receive pin synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end else begin
            rxd_meta <= i_rxd;
            rxd_sync <= rxd_meta;
        end
    end

    // Stop check: mid-bit sampling, first stop only
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !control[CT_RX_EN]) begin
            rx_busy     <= 1'b0;
            rx_ticks    <= 4'h0;
            rx_bits     <= 4'h0;
            frame_error <= 1'b0;
        end else if (!rx_busy) begin
            if (!rxd_sync && baud_tick) begin
                rx_busy  <= 1'b1;
                rx_ticks <= 4'h0;
                rx_bits  <= 4'h0;
            end
        end else if (baud_tick) begin
            rx_ticks <= (rx_ticks == ticks_per_bit) ? 4'h0 : rx_ticks + 4'h1;
            if (rx_ticks == {1'b0, ticks_per_bit[3:1]}) begin
                rx_bits <= rx_bits + 4'h1;
                // Bits: start, data, parity, then first stop
                if (rx_bits == data_bits + {3'b000, parity_on} + 4'h1) begin
                    frame_error <= !rxd_sync;
                    rx_busy     <= 1'b0;
                end
            end
        end
    end
    assign o_frame_error = frame_error;

    ////////////////////////////////////////////////////////////////////
    // Requests and read-back
    assign o_empty_irq = control[CT_EMPTY_IE] && !buffer_full;
    assign o_done_irq  = tx_done;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_STATUS:  o_rdata <= {i_rx_done, tx_done, !buffer_full,
                                          frame_error, 2'b00, double_speed, 1'b0};
                ADDR_CONTROL: o_rdata <= {control[7:2], i_rx_ninth, control[0]};
                ADDR_FORMAT:  o_rdata <= format;
                ADDR_BAUD_LO: o_rdata <= baud_div[7:0];
                default:      o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// *** logic/uart_parity_gen.sv ***
`timescale 1ns/10ps
module uart_parity_gen
    import uart_frame_pkg::*;
(
    // Character and format
    input  wire logic [8:0] i_data,
    input  wire logic [2:0] i_char_size,
    input  wire logic       i_odd,
    // Result
    output logic [8:0]      o_masked,
    output logic            o_parity
);

    logic [8:0] keep_mask;

    // Unused upper bits forced to zero so they never reach the line
    assign keep_mask = (i_char_size == CHAR_5) ? 9'h01F :
                       (i_char_size == CHAR_6) ? 9'h03F :
                       (i_char_size == CHAR_7) ? 9'h07F :
                       (i_char_size == CHAR_9) ? 9'h1FF : 9'h0FF;
    assign o_masked  = i_data & keep_mask;
    // Even is plain xor, odd inverts it
    assign o_parity  = (^o_masked) ^ i_odd;

endmodule

// *** pkg/uart_frame_pkg.sv ***
package uart_frame_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_DATA    = 3'h0;
    localparam logic [2:0] ADDR_STATUS  = 3'h1;
    localparam logic [2:0] ADDR_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_FORMAT  = 3'h3;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h4;

    // Status register bit positions
    localparam int ST_RX_DONE   = 7;
    localparam int ST_TX_DONE   = 6;
    localparam int ST_TX_EMPTY  = 5;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_DOUBLE    = 1;

    // Control register bit positions
    localparam int CT_EMPTY_IE  = 5;
    localparam int CT_RX_EN     = 4;
    localparam int CT_TX_EN     = 3;
    localparam int CT_CHAR_HI   = 2;
    localparam int CT_RX_NINTH  = 1;
    localparam int CT_TX_NINTH  = 0;

    // Format register layout; bit 7 selects it over the high baud byte
    localparam int FM_SELECT    = 7;
    localparam int FM_PAR_HI    = 5;
    localparam int FM_PAR_LO    = 4;
    localparam int FM_STOP2     = 3;
    localparam int FM_CHAR_HI   = 2;
    localparam int FM_CHAR_LO   = 1;

    // Character size codes
    localparam logic [2:0] CHAR_5 = 3'h0;
    localparam logic [2:0] CHAR_6 = 3'h1;
    localparam logic [2:0] CHAR_7 = 3'h2;
    localparam logic [2:0] CHAR_8 = 3'h3;
    localparam logic [2:0] CHAR_9 = 3'h7;

    // Reset values
    localparam logic [7:0] STATUS_RESET  = 8'h20;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] FORMAT_RESET  = 8'h06;
    localparam logic [11:0] BAUD_RESET   = 12'h000;

    // Last baud tick index of a bit (16 and 8 ticks): normal and double speed
    localparam logic [3:0] TICKS_NORMAL = 4'hF;
    localparam logic [3:0] TICKS_DOUBLE = 4'h7;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP1  = 3'b100,
        TX_STOP2  = 3'b101
    } tx_state_type;

endpackage

// *** testbench/tb_uart_frame_tx.sv ***
`timescale 1ns/10ps
module tb_uart_frame_tx;
    import uart_frame_pkg::*;
    logic       clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ack = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [3:0] pb = 4'h8;
    logic       pp = 1'b0, ps = 1'b0;
    wire  [7:0] o_rdata;
    wire        rxd, o_txd, o_txd_oe, o_empty_irq, o_done_irq, o_frame_error;
    wire  [8:0] p_data;
    wire        p_par;
    wire  [1:0] p_stops;
    int         p_frames, p_gap, cycles = 0, bad_count = 0, n_compared = 0;

    uart_frame_tx i_dut (.i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
        .i_rd(rd_s), .o_rdata(o_rdata), .i_rxd(rxd), .i_rx_done(1'b0), .i_rx_ninth(1'b0),
        .i_tx_done_ack(ack), .o_frame_error(o_frame_error), .o_txd(o_txd), .o_txd_oe(o_txd_oe),
        .o_empty_irq(o_empty_irq), .o_done_irq(o_done_irq));
    uart_remote_peer peer (.i_clk(clk), .i_line(o_txd), .i_bits(pb), .i_par_en(pp), .i_two_stop(ps),
        .o_line(rxd), .o_data(p_data), .o_par(p_par), .o_stops(p_stops), .o_frames(p_frames), .o_gap(p_gap));

    // 200 MHz clock and a hang guard well above the expected run
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (++cycles == 40000) begin bad_count++; final_report(); end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A gap cycle after each strobe keeps every strobe assigned once per step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a; wdata <= d; wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        addr <= a; rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        @(negedge clk) check({1'b0, o_rdata}, {1'b0, exp});
        @(posedge clk);
    endtask
    task automatic wait_frames(input int f);
        for (int k = 0; k < 800 && p_frames < f; k++) @(posedge clk);
        for (int k = 0; k < 40 && o_done_irq !== 1'b1; k++) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(ADDR_FORMAT, FORMAT_RESET);
        rd(3'h6, 8'h00);
        wr(ADDR_FORMAT, 8'h05);
        rd(ADDR_FORMAT, FORMAT_RESET);
        // Put the high divider byte back and restart the divider at full speed
        wr(ADDR_FORMAT, 8'h00);
        wr(ADDR_BAUD_LO, 8'h00);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, STATUS_RESET);
    endtask
    // One frame in the given format; the format only moves while the line idles
    task automatic send(input logic [2:0] sz, input logic [1:0] pm, input logic st, input logic [8:0] v);
        int n;
        int f;
        logic [8:0] m;
        n = (sz == CHAR_9) ? 9 : sz + 5;
        m = 9'(10'(v) & ((10'h001 << n) - 10'h001));
        pb <= 4'(n); pp <= pm[1]; ps <= st;
        wr(ADDR_STATUS, 8'h40);
        check({8'h00, o_done_irq}, 9'h000);
        wr(ADDR_FORMAT, {2'b10, pm, st, sz[1:0], 1'b0});
        wr(ADDR_CONTROL, {5'h03, sz[2], 1'b0, v[8]});
        f = p_frames;
        wr(ADDR_DATA, v[7:0]);
        wait_frames(f + 1);
        check(p_data, m);
        if (pm[1]) check({8'h00, p_par}, {8'h00, ^m ^ pm[0]});
        check({7'h00, p_stops}, 9'h003);
        check({8'h00, o_done_irq}, 9'h001);
    endtask
    task automatic t_formats;
        logic [2:0] sizes [5] = '{CHAR_5, CHAR_6, CHAR_7, CHAR_8, CHAR_9};
        logic [1:0] pars [3] = '{2'h0, 2'h2, 2'h3};
        for (int i = 0; i < 30; i++) send(sizes[i % 5], pars[(i / 5) % 3], i[0] ^ i[3], 9'(9'h0C3 + i * 37));
    endtask
    // Second byte written while the first is on the line
    task automatic t_b2b;
        int f;
        pb <= 4'h8; pp <= 1'b1; ps <= 1'b1;
        // Stale complete flag would end the wait before the second frame drains
        wr(ADDR_STATUS, 8'h40);
        wr(ADDR_FORMAT, 8'hAE);
        wr(ADDR_CONTROL, 8'h38);
        check({8'h00, o_empty_irq}, 9'h001);
        f = p_frames;
        wr(ADDR_DATA, 8'h3C);
        for (int k = 0; k < 10 && o_empty_irq !== 1'b1; k++) @(posedge clk);
        addr <= ADDR_DATA; wdata <= 8'hC3; wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
        @(negedge clk) check({8'h00, o_empty_irq}, 9'h000);
        wait_frames(f + 2);
        check(p_data, 9'h0C3);
        check(9'(p_gap), 9'(12 * 16));
        check({8'h00, o_done_irq}, 9'h001);
        wr(ADDR_CONTROL, 8'h18);
        check({8'h00, o_empty_irq}, 9'h000);
    endtask
    task automatic t_disable;
        int f;
        wr(ADDR_CONTROL, 8'h10);
        repeat (4) @(posedge clk);
        check({8'h00, o_txd_oe}, 9'h000);
        f = p_frames;
        wr(ADDR_DATA, 8'h55);
        repeat (300) @(posedge clk);
        check(9'(p_frames - f), 9'h000);
        rd(ADDR_STATUS, 8'h40);
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        @(negedge clk) check({8'h00, o_done_irq}, 9'h000);
        @(posedge clk);
        wr(ADDR_CONTROL, 8'h18);
        wait_frames(f + 1);
        check(p_data, 9'h055);
    endtask
    // Only the first stop level decides a frame error
    task automatic t_rx;
        wr(ADDR_FORMAT, 8'h86);
        peer.drive_frame(8, 1'b1, 1'b0);
        repeat (40) @(posedge clk);
        check({8'h00, o_frame_error}, 9'h000);
        // Low second stop looks like a start; let that false frame finish
        repeat (160) @(posedge clk);
        peer.drive_frame(8, 1'b0, 1'b1);
        repeat (40) @(posedge clk);
        check({8'h00, o_frame_error}, 9'h001);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_formats();
        t_b2b();
        t_disable();
        t_rx();
        final_report();
    end
endmodule

// *** testbench/uart_frame_props.sv ***
`timescale 1ns/10ps
module uart_frame_props
    import uart_frame_pkg::*;
(
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_resetn,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Line and requests
    input wire logic       i_tx_done_ack,
    input wire logic       o_txd,
    input wire logic       o_txd_oe,
    input wire logic       o_empty_irq,
    input wire logic       o_done_irq
);
    // Status write that clears the complete flag
    wire done_wr1 = i_wr && (i_addr == ADDR_STATUS) && i_wdata[ST_TX_DONE];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Reset state has its own check, so the reset itself is not a disable here
    a_reset_quiet: assert property (@(posedge i_clk) disable iff (1'b0)
        !i_resetn |=> o_txd && !o_txd_oe && !o_done_irq && (o_rdata == 8'h00))
        else $error("reset state of line or flags wrong");
    a_read_data_once: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_write_fills_buf: assert property ((i_wr && i_addr == ADDR_DATA) |=> !o_empty_irq)
        else $error("empty request after data write");
    // Bits last at least eight clocks at any speed
    a_start_bit_low: assert property ($fell(o_txd) |-> !o_txd [*8])
        else $error("start bit too short");
    a_stop_bit_high: assert property ($rose(o_txd) |-> o_txd [*8])
        else $error("high bit too short");
    a_low_only_driven: assert property (!o_txd |-> o_txd_oe)
        else $error("line low while not driven");
    a_done_on_idle: assert property ($rose(o_done_irq) |-> o_txd)
        else $error("complete flag rose mid bit low");
    a_done_holds: assert property ((o_done_irq && !i_tx_done_ack && !done_wr1) |=> o_done_irq)
        else $error("complete flag dropped by itself");
    a_done_clears: assert property (((i_tx_done_ack || done_wr1) && !o_txd_oe) |=> !o_done_irq)
        else $error("complete flag not cleared");
endmodule

bind uart_frame_tx uart_frame_props i_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_done_ack(i_tx_done_ack),
    .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_empty_irq(o_empty_irq), .o_done_irq(o_done_irq));

// *** testbench/uart_remote_peer.sv ***
`timescale 1ns/10ps
module uart_remote_peer #(parameter int BIT = 16) (
    // Clock and line in
    input  wire logic       i_clk,
    input  wire logic       i_line,
    // Expected format
    input  wire logic [3:0] i_bits,
    input  wire logic       i_par_en,
    input  wire logic       i_two_stop,
    // Line out and captured frame
    output logic            o_line,
    output logic [8:0]      o_data,
    output logic            o_par,
    output logic [1:0]      o_stops,
    output int              o_frames,
    output int              o_gap
);
    int cyc = 0;
    int last = 0;
    initial o_line = 1'b1;
    initial o_frames = 0;
    always @(negedge i_clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////
    // Mid-bit sampler on the falling edge, clear of the launch edge
    always begin
        @(negedge i_clk);
        if (i_line === 1'b0) begin
            o_gap = cyc - last;
            last = cyc;
            o_data = 9'h000;
            o_stops = 2'b11;
            repeat (BIT / 2) @(negedge i_clk);
            for (int k = 0; k < i_bits; k++) begin
                repeat (BIT) @(negedge i_clk);
                o_data[k] = i_line;
            end
            if (i_par_en) begin
                repeat (BIT) @(negedge i_clk);
                o_par = i_line;
            end
            repeat (BIT) @(negedge i_clk);
            o_stops[0] = i_line;
            if (i_two_stop) begin
                repeat (BIT) @(negedge i_clk);
                o_stops[1] = i_line;
            end
            o_frames++;
        end
    end
    // Sends one frame on the receive line with chosen stop levels
    task automatic drive_frame(input int n, input logic s1, input logic s2);
        for (int k = 0; k < n + 3; k++) begin
            o_line = (k == 0) ? 1'b0 : (k <= n) ? k[0] : (k == n + 1) ? s1 : s2;
            repeat (BIT) @(negedge i_clk);
        end
        o_line = 1'b1;
    endtask
endmodule
